// *** ext_clock_source_model.sv ***
// External crystal, RC network or clock driver on the two clock pins
module ext_clock_source_model (
    input  wire logic pclk,
    input  wire logic run,
    input  wire logic in_oe,
    input  wire logic in_o,
    input  wire logic out_oe,
    input  wire logic out_o,
    output logic      in_level,
    output logic      out_level
);
    timeunit 1ns;
    timeprecision 1ns;
    logic src = 1'h0;
    logic idle = 1'h0;
    // Half pclk: inside the times-four input ceiling
    always_ff @(posedge pclk) begin
        src  <= run ? !src : src;
        idle <= !idle;
    end
    // An undriven output pin always shows a moving pattern; the undriven input pin moves only while run is high
    assign in_level  = in_oe ? in_o : src;
    assign out_level = out_oe ? out_o : idle;
endmodule : ext_clock_source_model

// *** oscillator_mode_clock_select.sv ***
// Oscillator mode decode, postscaler and clock pin steering
//
// What this block does
// R1: Crystal modes run amplifier across pins
// R2: Fast crystal mode takes external clock
// R3: Times-four reference at most 10 MHz
// R4: Times-four mode multiplies by four
// R5: PLL on only in times-four mode
// R6: External clock modes skip start-up
// R7: External clock mode drives clock/4
// R8: External clock I/O mode frees bit six
// R9: RC mode drives clock/4
// R10: RC I/O mode frees bit six
// R11: Fast oscillator gives 8 MHz directly
// R12: Postscaler gives 125 kHz to 4 MHz
// R13: Fast oscillator on for postscaled choices
// R14: Slow oscillator gives nominal 31 kHz
// R15: Slow oscillator runs for block or features
// R16: Choice comes from control register
// R17: Internal mode one: clock/4, bit seven I/O
// R18: Internal mode two: both pins I/O
// R19: Four-bit strap picks one of ten
// R20: Choice codes 111 fast to 000 slow
// R21: Unused clock output pin goes to port
// R22: Changes among choices 001 to 111 make no short pulses
module oscillator_mode_clock_select
    import oscillator_mode_pkg::*;
(
    input  wire logic                                    pclk,
    input  wire logic                                    presetn,
    input  wire logic                                    psel,
    input  wire logic                                    penable,
    input  wire logic                                    pwrite,
    input  wire logic [oscillator_mode_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                             pwdata,
    output logic      [31:0]                             prdata,
    output logic                                         pready,
    output logic                                         pslverr,
    input  wire logic [3:0]                              oscillator_mode_config_bits,
    input  wire logic                                    clock_in_pin_i,
    output logic                                         clock_in_pin_o,
    output logic                                         clock_in_pin_oe,
    input  wire logic                                    clock_out_pin_i,
    output logic                                         clock_out_pin_o,
    output logic                                         clock_out_pin_oe,
    output logic                                         osc_amp_enable,
    output logic                                         pll_enable,
    input  wire logic                                    pll_clk,
    input  wire logic                                    fast_osc_clk,
    input  wire logic                                    slow_osc_clk,
    output logic                                         fast_osc_enable,
    output logic                                         slow_osc_enable,
    input  wire logic                                    wake_from_sleep,
    input  wire logic                                    port_a_bit_six_out,
    input  wire logic                                    port_a_bit_six_oe,
    output logic                                         port_a_bit_six_in,
    input  wire logic                                    port_a_bit_seven_out,
    input  wire logic                                    port_a_bit_seven_oe,
    output logic                                         port_a_bit_seven_in,
    output logic                                         sys_clk_out,
    output logic                                         primary_ready
);
    import oscillator_mode_pkg::*;
    // Mode class decoding, shared by several processes
    function automatic logic uses_amp(input logic [3:0] m);
        return (m == LOW_POWER_CRYSTAL_MODE) || (m == STANDARD_CRYSTAL_MODE) ||
               (m == FAST_CRYSTAL_MODE) || (m == FAST_CRYSTAL_TIMES_FOUR_MODE);
    endfunction : uses_amp
    function automatic logic is_internal(input logic [3:0] m);
        return (m == INTERNAL_OSC_DIV4_OUT_MODE) || (m == INTERNAL_OSC_TWO_PIN_IO_MODE);
    endfunction : is_internal
    function automatic logic drives_div4(input logic [3:0] m);
        return (m == EXT_CLOCK_DIV4_OUT_MODE) || (m == RESISTOR_CAPACITOR_MODE) ||
               (m == INTERNAL_OSC_DIV4_OUT_MODE);
    endfunction : drives_div4
    function automatic logic uses_slow(input logic [2:0] c);
        return c == CHOICE_SLOW_DIRECT;
    endfunction : uses_slow
    // Synchroniser: stage one is read by stage two only
    logic [SYNC_W-1:0] sync_meta;
    logic [SYNC_W-1:0] sync_q;
    logic              pll_lvl;
    logic              fast_lvl;
    logic              slow_lvl;
    logic              clk_in_lvl;
    logic              clk_out_pin_lvl;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_meta <= '0;
            sync_q    <= '0;
        end else begin
            sync_meta <= {pll_clk, fast_osc_clk, slow_osc_clk, clock_in_pin_i, clock_out_pin_i};
            sync_q    <= sync_meta;
        end
    end

    assign {pll_lvl, fast_lvl, slow_lvl, clk_in_lvl, clk_out_pin_lvl} = sync_q;
    // Edge history of the synchronised levels
    logic fast_prev;
    logic clk_in_prev;
    logic fast_rise;
    logic clk_in_rise;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_prev   <= 1'b0;
            clk_in_prev <= 1'b0;
        end else begin
            fast_prev   <= fast_lvl;
            clk_in_prev <= clk_in_lvl;
        end
    end

    assign fast_rise   = fast_lvl & ~fast_prev;
    assign clk_in_rise = clk_in_lvl & ~clk_in_prev;
    // Strap caught once after reset, then held
    src_state_t        state;
    logic [3:0]        mode;
    logic [STARTUP_W-1:0] startup_cnt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= LOW_POWER_CRYSTAL_MODE;
        end else if (state == ST_STRAP) begin
            mode <= oscillator_mode_config_bits; // R19
        end
    end

    // Crystal modes wait out the start-up count; the rest run at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state       <= ST_STRAP;
            startup_cnt <= '0;
        end else begin
            case (state)
                ST_STRAP: begin
                    startup_cnt <= '0;
                    if (uses_amp(oscillator_mode_config_bits)) begin
                        state <= ST_STARTUP;
                    end else begin
                        state <= ST_RUN; // R6
                    end
                end
                ST_STARTUP: begin
                    if (clk_in_rise) begin
                        startup_cnt <= startup_cnt + 1'b1;
                    end
                    if (startup_cnt == STARTUP_EDGES) begin
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    // A wake restarts the wait for crystals only
                    if (wake_from_sleep && uses_amp(mode)) begin
                        startup_cnt <= '0;
                        state       <= ST_STARTUP;
                    end
                end
                default: begin
                    state <= ST_STRAP;
                end
            endcase
        end
    end

    // Control register
    logic [2:0] choice_req;
    logic       powerup_timer_en;
    logic       failsafe_en;
    logic       watchdog_en;
    logic       two_speed_en;
    logic       access;
    logic       addr_ok;

    assign access  = psel & penable & ~pready;
    assign addr_ok = (paddr == CONTROL_OFFSET) || (paddr == STATUS_OFFSET) ||
                     (paddr == PIN_STATE_OFFSET);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            choice_req       <= CHOICE_RESET;
            powerup_timer_en <= 1'b0;
            failsafe_en      <= 1'b0;
            watchdog_en      <= 1'b0;
            two_speed_en     <= 1'b0;
        end else if (access && pwrite && paddr == CONTROL_OFFSET) begin
            choice_req       <= pwdata[CTRL_CHOICE_LSB +: 3]; // R16
            powerup_timer_en <= pwdata[CTRL_POWERUP_BIT];
            failsafe_en      <= pwdata[CTRL_FAILSAFE_BIT];
            watchdog_en      <= pwdata[CTRL_WATCHDOG_BIT];
            two_speed_en     <= pwdata[CTRL_TWOSPEED_BIT];
        end
    end

    // Postscaler: bit k of the counter is the fast clock divided by 2^(k+1)
    logic [POST_W-1:0] post_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            post_cnt <= POST_ZERO;
        end else if (!fast_osc_enable) begin
            post_cnt <= POST_ZERO;
        end else if (fast_rise) begin
            post_cnt <= post_cnt + 1'b1; // R12
        end
    end

    // Choice moves with old and new outputs low, or at once while the fast oscillator is off
    logic [2:0] choice_act;
    logic       switch_ok;

    assign switch_ok = (post_cnt == POST_ZERO) && !fast_lvl &&
                       (!(uses_slow(choice_act) || uses_slow(choice_req)) || !slow_lvl);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            choice_act <= CHOICE_RESET;
        end else if (choice_req != choice_act) begin
            if (switch_ok || !fast_osc_enable) begin
                choice_act <= choice_req; // R22
            end
        end
    end

    // Internal block output for the live choice
    logic       int_level;
    logic [2:0] post_idx;

    assign post_idx = CHOICE_4MHZ - choice_act;
    always_comb begin
        case (choice_act)
            CHOICE_FAST_DIRECT: int_level = fast_lvl;             // R11 R20
            CHOICE_SLOW_DIRECT: int_level = slow_lvl;             // R14 R20
            default:            int_level = post_cnt[post_idx];   // R12 R20
        endcase
    end

    // System clock source: internal block, multiplied crystal or pin clock
    logic sys_src_level;
    always_comb begin
        if (is_internal(mode)) begin
            sys_src_level = int_level;
        end else if (mode == FAST_CRYSTAL_TIMES_FOUR_MODE) begin
            sys_src_level = pll_lvl; // R4
        end else begin
            sys_src_level = clk_in_lvl; // R2
        end
    end

    logic [1:0] div4_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_clk_out   <= 1'b0;
            primary_ready <= 1'b0;
            div4_cnt      <= 2'h0;
        end else begin
            sys_clk_out   <= (state == ST_RUN) ? sys_src_level : 1'b0; // R6
            primary_ready <= (state == ST_RUN);
            if (state == ST_RUN && sys_src_level && !sys_clk_out) begin
                div4_cnt <= div4_cnt + 1'b1;
            end
        end
    end

    // Oscillator enables; the PLL multiplies its reference by PLL_FACTOR
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_amp_enable  <= 1'b0;
            pll_enable      <= 1'b0;
            fast_osc_enable <= 1'b0;
            slow_osc_enable <= 1'b0;
        end else begin
            osc_amp_enable  <= (state != ST_STRAP) && uses_amp(mode); // R1
            pll_enable      <= (state != ST_STRAP) &&
                               (mode == FAST_CRYSTAL_TIMES_FOUR_MODE); // R5
            fast_osc_enable <= is_internal(mode) && !uses_slow(choice_req); // R13
            slow_osc_enable <= is_internal(mode) || powerup_timer_en || failsafe_en ||
                               watchdog_en || two_speed_en; // R15
        end
    end

    // Pin steering; both pins stay undriven until the strap is taken
    logic pin6_is_io;
    logic pin7_is_io;

    assign pin6_is_io = (state != ST_STRAP) && !uses_amp(mode) && !drives_div4(mode);
    assign pin7_is_io = (state != ST_STRAP) && is_internal(mode);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_out_pin_o     <= 1'b0;
            clock_out_pin_oe    <= 1'b0;
            clock_in_pin_o      <= 1'b0;
            clock_in_pin_oe     <= 1'b0;
            port_a_bit_six_in   <= 1'b0;
            port_a_bit_seven_in <= 1'b0;
        end else begin
            if (state != ST_STRAP && drives_div4(mode)) begin
                clock_out_pin_o  <= div4_cnt[1]; // R7 R9 R17
                clock_out_pin_oe <= 1'b1;
            end else if (pin6_is_io) begin
                clock_out_pin_o  <= port_a_bit_six_out; // R8 R10 R18 R21
                clock_out_pin_oe <= port_a_bit_six_oe;
            end else begin
                // Amplifier owns the pin in crystal modes
                clock_out_pin_o  <= 1'b0;
                clock_out_pin_oe <= 1'b0;
            end
            if (pin7_is_io) begin
                clock_in_pin_o  <= port_a_bit_seven_out; // R17 R18
                clock_in_pin_oe <= port_a_bit_seven_oe;
            end else begin
                clock_in_pin_o  <= 1'b0;
                clock_in_pin_oe <= 1'b0;
            end
            port_a_bit_six_in   <= pin6_is_io ? clk_out_pin_lvl : 1'b0; // R21
            port_a_bit_seven_in <= pin7_is_io ? clk_in_lvl : 1'b0;
        end
    end

    // APB slave: one wait state, all answers registered
    logic [31:0] read_word;
    always_comb begin
        read_word = '0;
        case (paddr)
            CONTROL_OFFSET: begin
                read_word[CTRL_CHOICE_LSB +: 3] = choice_req;
                read_word[CTRL_POWERUP_BIT]     = powerup_timer_en;
                read_word[CTRL_FAILSAFE_BIT]    = failsafe_en;
                read_word[CTRL_WATCHDOG_BIT]    = watchdog_en;
                read_word[CTRL_TWOSPEED_BIT]    = two_speed_en;
            end
            STATUS_OFFSET: begin
                read_word[3:0]   = mode;
                read_word[4]     = pll_enable;
                read_word[5]     = primary_ready;
                read_word[6]     = fast_osc_enable;
                read_word[7]     = slow_osc_enable;
                read_word[10:8]  = choice_act;
                read_word[11]    = pin6_is_io;
                read_word[12]    = pin7_is_io;
                read_word[13]    = osc_amp_enable;
                read_word[14]    = sys_clk_out;
            end
            PIN_STATE_OFFSET: begin
                read_word[0] = port_a_bit_six_in;
                read_word[1] = port_a_bit_seven_in;
            end
            default: read_word = '0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= access;
            pslverr <= access && !addr_ok;
            if (access && !pwrite) begin
                prdata <= read_word;
            end
        end
    end

endmodule : oscillator_mode_clock_select

// *** oscillator_mode_clock_select_chk.sv ***
// Checker: mode decode, pin steering, clock output, bus timing
module oscillator_mode_clock_select_chk
    import oscillator_mode_pkg::*;
(
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic [3:0] oscillator_mode_config_bits,
    input wire logic       clock_out_pin_o,
    input wire logic       clock_out_pin_oe,
    input wire logic       clock_in_pin_oe,
    input wire logic       osc_amp_enable,
    input wire logic       pll_enable,
    input wire logic       fast_osc_enable,
    input wire logic       slow_osc_enable,
    input wire logic       sys_clk_out,
    input wire logic       primary_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] md;
    logic [2:0] age;
    logic       xtal, ext, intl, div4, done;
    assign md   = oscillator_mode_config_bits;
    assign xtal = md inside {LOW_POWER_CRYSTAL_MODE, STANDARD_CRYSTAL_MODE, FAST_CRYSTAL_MODE,
                             FAST_CRYSTAL_TIMES_FOUR_MODE};
    assign ext  = md inside {EXT_CLOCK_DIV4_OUT_MODE, EXT_CLOCK_PIN_IO_MODE};
    assign intl = md inside {INTERNAL_OSC_DIV4_OUT_MODE, INTERNAL_OSC_TWO_PIN_IO_MODE};
    assign div4 = md inside {EXT_CLOCK_DIV4_OUT_MODE, RESISTOR_CAPACITOR_MODE,
                             INTERNAL_OSC_DIV4_OUT_MODE};
    // Outputs settle by the second edge after reset
    assign done = age >= 3'h3;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age <= 3'h0;
        end else if (age != 3'h7) begin
            age <= age + 3'h1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_wait; psel && penable && !pready; endsequence
    sequence s_sys_rise; !sys_clk_out ##1 sys_clk_out; endsequence
    a_pll_mode_only: assert property (pll_enable |-> md == FAST_CRYSTAL_TIMES_FOUR_MODE)
        else $error("pll enabled outside times-four mode");
    a_pll_on_x4: assert property (done && md == FAST_CRYSTAL_TIMES_FOUR_MODE |-> pll_enable)
        else $error("pll off in times-four mode");
    a_amp_crystal: assert property (osc_amp_enable |-> xtal)
        else $error("amplifier on outside crystal modes");
    a_ext_no_wait: assert property (ext && age == 3'h3 |-> ##[0:3] primary_ready)
        else $error("external clock waited for start-up");
    a_fast_int_only: assert property (fast_osc_enable |-> intl)
        else $error("fast oscillator on outside internal modes");
    a_slow_int_on: assert property (intl && done |-> slow_osc_enable)
        else $error("slow oscillator off in internal mode");
    a_div4_drives: assert property (div4 && done |-> clock_out_pin_oe)
        else $error("clock output pin not driven");
    a_div4_rate: assert property (div4 && done && $changed(clock_out_pin_o) |->
        $past(sys_clk_out) && !$past(sys_clk_out, 2))
        else $error("clock output toggled without a system clock rise");
    a_in_pin_free: assert property (!intl && done |-> !clock_in_pin_oe)
        else $error("clock input pin driven outside internal modes");
    a_no_runt: assert property ((intl && done) ##0 s_sys_rise |=> sys_clk_out)
        else $error("short system clock pulse");
    a_apb_answer: assert property (s_wait |=> pready)
        else $error("bus access not answered");
endmodule : oscillator_mode_clock_select_chk

bind oscillator_mode_clock_select oscillator_mode_clock_select_chk
    oscillator_mode_clock_select_chk_i (.*);

// *** oscillator_mode_clock_select_test.sv ***
// Bench: mode sweep, pin steering, clock rates and register access
module oscillator_mode_clock_select_test;
    import oscillator_mode_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, run, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [3:0]  oscillator_mode_config_bits;
    logic        clock_in_pin_i, clock_in_pin_o, clock_in_pin_oe;
    logic        clock_out_pin_i, clock_out_pin_o, clock_out_pin_oe;
    logic        osc_amp_enable, pll_enable, pll_clk, fast_osc_clk, slow_osc_clk;
    logic        fast_osc_enable, slow_osc_enable, wake_from_sleep, sys_clk_out, primary_ready;
    logic        port_a_bit_six_out, port_a_bit_six_oe, port_a_bit_six_in;
    logic        port_a_bit_seven_out, port_a_bit_seven_oe, port_a_bit_seven_in;
    logic [4:0]  osc_cnt;
    int          error_cnt, num_checks, rises, togs;
    logic [3:0]  modes [10] = '{LOW_POWER_CRYSTAL_MODE, STANDARD_CRYSTAL_MODE, FAST_CRYSTAL_MODE,
        FAST_CRYSTAL_TIMES_FOUR_MODE, RESISTOR_CAPACITOR_MODE, RESISTOR_CAPACITOR_PIN_IO_MODE,
        INTERNAL_OSC_DIV4_OUT_MODE, INTERNAL_OSC_TWO_PIN_IO_MODE, EXT_CLOCK_DIV4_OUT_MODE,
        EXT_CLOCK_PIN_IO_MODE};

    oscillator_mode_clock_select oscillator_mode_clock_select_i (.*);
    ext_clock_source_model ext_clock_source_model_i (
        .pclk, .run, .in_oe(clock_in_pin_oe), .in_o(clock_in_pin_o), .out_oe(clock_out_pin_oe),
        .out_o(clock_out_pin_o), .in_level(clock_in_pin_i), .out_level(clock_out_pin_i)
    );

    initial begin
        pclk = 1'h0;
        forever #50 pclk = ~pclk;
    end
    // Internal oscillators at fixed fractions of pclk
    always @(posedge pclk) begin
        osc_cnt      <= osc_cnt + 5'h1;
        pll_clk      <= osc_cnt[0];
        fast_osc_clk <= osc_cnt[1];
        slow_osc_clk <= osc_cnt[4];
    end

    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xorshift

    task automatic check(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'h1) begin
            $display("ERROR %0t %s", $time, msg);
            error_cnt++;
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    // Leading edge keeps back-to-back calls from writing psel twice in one step;
    // pready is looked at mid-cycle so the edge's own updates cannot race it
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        if (n >= 50) begin
            check(1'h0, "bus timeout");
            conclude();
        end
        {rd, err} = {prdata, pslverr};
        @(posedge pclk);
        {psel, penable} <= 2'h0;
    endtask : apb

    task automatic measure(input int n);
        logic s, o;
        {rises, togs} = '0;
        repeat (n) begin
            {s, o} = {sys_clk_out, clock_out_pin_o};
            @(negedge pclk);
            rises += int'(sys_clk_out && !s);
            togs  += int'(clock_out_pin_o !== o);
        end
    endtask : measure

    // Sweep order: four crystal, RC, RC I/O, two internal, two external clock
    task automatic run_mode(input int k);
        logic [3:0]  m;
        logic        xtal, intl, div4, io6, v6, v7;
        logic [31:0] d;
        int          n, exp;
        m    = modes[k];
        xtal = k < 4;
        intl = k inside {6, 7};
        div4 = k inside {4, 6, 8};
        io6  = k inside {5, 7, 9};
        seed = xorshift(seed);
        v6 = seed[0];
        v7 = seed[1];
        presetn <= 1'h0;
        oscillator_mode_config_bits <= m;
        run <= !intl;
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        port_a_bit_six_out   <= v6;
        port_a_bit_seven_out <= v7;
        repeat (20) @(negedge pclk);
        check(pll_enable === (m == FAST_CRYSTAL_TIMES_FOUR_MODE), "pll enable");
        check(primary_ready === !xtal, "start-up wait");
        check(clock_out_pin_oe === (div4 | io6), "clock out drive");
        check(!io6 || clock_out_pin_o === v6, "bit six drive");
        check(port_a_bit_six_in === (io6 & v6), "bit six input");
        check(clock_in_pin_oe === intl && (!intl || clock_in_pin_o === v7), "bit seven");
        check(port_a_bit_seven_in === (intl & v7), "bit seven input");
        n = 0;
        while (primary_ready !== 1'h1 && n < 3000) begin
            @(negedge pclk);
            n++;
        end
        check(primary_ready === 1'h1, "source never ran");
        if (xtal) check(n + 21 >= 2 * STARTUP_EDGES, "start-up too short");
        check(osc_amp_enable === xtal, "amplifier");
        measure(200);
        check(intl || rises >= 90, "primary clock rate");
        if (div4) check(2 * togs <= rises + 2 && 2 * togs + 2 >= rises, "clock/4 rate");
        if (io6) check(togs == 0, "bit six disturbed");
        apb(1'h0, STATUS_OFFSET, 32'h0);
        check(rd[3:0] === m && rd[4] === pll_enable, "status mode");
        apb(1'h0, 8'h3C, 32'h0);
        check(err === 1'h1 && rd === 32'h0, "unmapped read");
        if (intl) begin
            for (int ch = 7; ch >= 0; ch--) begin
                seed = xorshift(seed);
                d = {25'h0, seed[3:0], 3'(ch)};
                apb(1'h1, CONTROL_OFFSET, d);
                apb(1'h0, CONTROL_OFFSET, 32'h0);
                check(rd === d, "control readback");
                repeat (300) @(negedge pclk);
                check(fast_osc_enable === (ch != 0), "fast osc enable");
                measure(1024);
                exp = (ch == 0) ? 32 : (256 >> (7 - ch));
                check(rises + 2 >= exp && rises <= exp + 2, "internal rate");
            end
        end else begin
            for (int b = 2; b <= 6; b++) begin
                apb(1'h1, CONTROL_OFFSET, 32'h1 << b);
                repeat (3) @(negedge pclk);
                check(slow_osc_enable === (b > 2), "slow osc request");
            end
        end
    endtask : run_mode

    initial begin
        {presetn, psel, penable, pwrite, run, wake_from_sleep} = '0;
        {port_a_bit_six_out, port_a_bit_six_oe, port_a_bit_seven_out, port_a_bit_seven_oe} = '1;
        {paddr, pwdata, osc_cnt, oscillator_mode_config_bits, error_cnt, num_checks} = '0;
        seed = 32'h0000_5726;
        foreach (modes[k]) run_mode(k);
        conclude();
    end
    initial begin
        repeat (100000) @(posedge pclk);
        check(1'h0, "run timeout");
        conclude();
    end
endmodule : oscillator_mode_clock_select_test

// *** oscillator_mode_pkg.sv ***
// Constants, codes and types shared by the oscillator mode clock select block
package oscillator_mode_pkg;

    // Register map, byte addresses on the APB
    localparam int          ADDR_W             = 8;
    localparam logic [7:0]  CONTROL_OFFSET     = 8'h00;
    localparam logic [7:0]  STATUS_OFFSET      = 8'h04;
    localparam logic [7:0]  PIN_STATE_OFFSET   = 8'h08;

    // Control register fields
    localparam int          CTRL_CHOICE_LSB    = 0;
    localparam int          CTRL_POWERUP_BIT   = 3;
    localparam int          CTRL_FAILSAFE_BIT  = 4;
    localparam int          CTRL_WATCHDOG_BIT  = 5;
    localparam int          CTRL_TWOSPEED_BIT  = 6;
    localparam logic [2:0]  CHOICE_RESET       = 3'h0;

    // Oscillator mode codes held in the four configuration bits
    localparam logic [3:0]  LOW_POWER_CRYSTAL_MODE         = 4'h0;
    localparam logic [3:0]  STANDARD_CRYSTAL_MODE          = 4'h1;
    localparam logic [3:0]  FAST_CRYSTAL_MODE              = 4'h2;
    localparam logic [3:0]  FAST_CRYSTAL_TIMES_FOUR_MODE   = 4'h6;
    localparam logic [3:0]  RESISTOR_CAPACITOR_MODE        = 4'h7;
    localparam logic [3:0]  RESISTOR_CAPACITOR_PIN_IO_MODE = 4'hC;
    localparam logic [3:0]  INTERNAL_OSC_DIV4_OUT_MODE     = 4'h9;
    localparam logic [3:0]  INTERNAL_OSC_TWO_PIN_IO_MODE   = 4'h8;
    localparam logic [3:0]  EXT_CLOCK_DIV4_OUT_MODE        = 4'h4;
    localparam logic [3:0]  EXT_CLOCK_PIN_IO_MODE          = 4'h5;

    // Internal frequency choice codes
    localparam logic [2:0]  CHOICE_SLOW_DIRECT = 3'h0;
    localparam logic [2:0]  CHOICE_4MHZ        = 3'h6;
    localparam logic [2:0]  CHOICE_FAST_DIRECT = 3'h7;

    // Postscaler reaches divide by 64 (8 MHz down to 125 kHz)
    localparam int          POST_W             = 6;
    localparam logic [5:0]  POST_ZERO          = 6'h00;
    localparam int          PLL_FACTOR         = 4;

    // Crystal start-up wait, counted in edges of the crystal clock
    localparam int          STARTUP_W          = 11;
    localparam logic [10:0] STARTUP_EDGES      = 11'h400;

    // Number of oscillator and pin inputs passing the two-stage synchroniser
    localparam int          SYNC_W             = 5;

    typedef enum logic [2:0] {
        ST_STRAP   = 3'b001,
        ST_STARTUP = 3'b010,
        ST_RUN     = 3'b100
    } src_state_t;

endpackage : oscillator_mode_pkg
